/* File: inc/iss_regs.svh */
// register offsets, field positions and reset values of the i2c slave block
`ifndef ISS_REGS_SVH
`define ISS_REGS_SVH
`define ISS_OFF_STAT_CTRL 12'h000
`define ISS_OFF_ENABLE    12'h004
`define ISS_OFF_OWN_ADDR  12'h008
`define ISS_OFF_DATA      12'h00c
`define ISS_OFF_INT_STAT  12'h010
`define ISS_OFF_INT_MASK  12'h014
`define ISS_BIT_DONE      7
`define ISS_BIT_MATCH     6
`define ISS_BIT_BUSY      5
`define ISS_BIT_DIR       4
`define ISS_BIT_TX_ACK    3
`define ISS_BIT_RW        2
`define ISS_BIT_WAKE      1
`define ISS_BIT_RX_ACK    0
`define ISS_INT_MATCH     0
`define ISS_INT_DONE      1
`define ISS_RST_DONE      1'h1
`define ISS_RST_RX_ACK    1'h1
`define ISS_BYTE_BITS     4'h8
`endif

/* File: inc/iss_pkg.sv */
// types shared by the i2c slave status and control block
package iss_pkg;
  typedef enum logic [2:0] {
    ISS_IDLE, ISS_ADDR, ISS_A_ACK, ISS_HOLD, ISS_RX, ISS_R_ACK, ISS_TX,
    ISS_T_ACK
  } iss_state_t;
  typedef logic [31:0] iss_word_t;
endpackage

/* File: inc/iss_link_if.sv */
// line events passed from the line monitor to the protocol core
`timescale 1ns/10ps
interface iss_link_if;
  logic scl_rise;  // one-cycle pulse, clock line rose
  logic scl_fall;  // one-cycle pulse, clock line fell
  logic sda_lvl;   // synchronised data line level
  logic start_det; // one-cycle pulse, start condition
  logic stop_det;  // one-cycle pulse, stop condition
  modport mon (output scl_rise, scl_fall, sda_lvl, start_det, stop_det);
  modport core (input scl_rise, scl_fall, sda_lvl, start_det, stop_det);
endinterface

/* File: src/iss_line_mon.sv */
// two-flop synchronisers and start, stop and edge detection on the lines
`timescale 1ns/10ps
module iss_line_mon
  import iss_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  iss_link_if.mon   link
);
  // all state of the monitor in one word
  typedef struct packed {
    logic [1:0] scl_sync; // [0] first stage, read only by [1]
    logic [1:0] sda_sync;
    logic       scl_prev; // last synchronised clock level
    logic       sda_prev; // last synchronised data level
  } iss_mon_t;

  iss_mon_t s_ff;
  iss_mon_t nxt_s;

  // shift the pins through, first stage only feeds second stage
  always_comb begin
    nxt_s          = s_ff;
    nxt_s.scl_sync = {s_ff.scl_sync[0], scl_in};
    nxt_s.sda_sync = {s_ff.sda_sync[0], sda_in};
    nxt_s.scl_prev = s_ff.scl_sync[1];
    nxt_s.sda_prev = s_ff.sda_sync[1];
  end

  // lines idle high, so reset to high avoids a false start after release
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_ff <= '1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // data changing while clock is high marks start or stop
  assign link.scl_rise  = s_ff.scl_sync[1] & ~s_ff.scl_prev;
  assign link.scl_fall  = ~s_ff.scl_sync[1] & s_ff.scl_prev;
  assign link.sda_lvl   = s_ff.sda_sync[1];
  assign link.start_det = s_ff.scl_sync[1] & s_ff.scl_prev &
                          s_ff.sda_prev & ~s_ff.sda_sync[1];
  assign link.stop_det  = s_ff.scl_sync[1] & s_ff.scl_prev &
                          ~s_ff.sda_prev & s_ff.sda_sync[1];
endmodule

/* File: src/iss_top.sv */
// i2c slave status and control with apb registers
// Function
// - done flag low in byte, set after eight
// - start condition clears the done flag
// - reading received data clears done flag
// - stop condition sets the done flag
// - match flag shows address equals own address
// - busy set by start, cleared by stop
// - direction bit selects receive or transmit
// - ack bit driven on ninth clock
// - rw flag reports master direction
// - wake enable plus match wakes device
// - ninth clock ack level in transmit loads rx ack flag, high on no ack
// - transmit until no ack, then release
// - enable rising edge resets status flags
// - eighth address bit captured as direction
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "iss_regs.svh"
module iss_top
  import iss_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire iss_pkg::iss_word_t pwdata,
  output logic                  pready,
  output iss_pkg::iss_word_t    prdata,
  output logic                  pslverr,
  input  wire logic             scl_in,
  output logic                  scl_out,
  output logic                  scl_oe,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  output logic                  irq,
  output logic                  wake_req
);
  import iss_pkg::*;

  // every piece of state of the block except the line monitor's own
  typedef struct packed {
    iss_state_t st;        // protocol phase
    logic [3:0] cnt;       // bits moved in this byte
    logic [7:0] shift;     // serial shift register
    logic [7:0] rx_data;   // last received byte
    logic [7:0] tx_data;   // byte queued by software
    logic [6:0] own_addr;  // stored slave address
    logic       en;        // interface enable
    logic       en_prev;   // enable one cycle ago
    logic       done;      // transfer complete flag
    logic       match;     // address match flag
    logic       busy;      // bus busy flag
    logic       dir;       // transmit when high
    logic       tx_ack_bit;  // ack bit to send
    logic       rw;        // master direction
    logic       wake_en;   // wake on address enable
    logic       rx_ack_flag; // ack bit read from master, high on no ack
    logic [1:0] int_stat;  // sticky event bits
    logic [1:0] int_mask;  // event enables
    logic       irq;       // interrupt line
    logic       wake;      // wake request
    logic       sda_oe;    // pulling data low
    logic       scl_oe;    // stretching clock low
    logic       pready;    // apb answer
    logic       pslverr;   // apb error
    iss_word_t  prdata;    // apb read data
  } iss_state_word_t;

  iss_state_word_t s_ff;    // registered state
  iss_state_word_t nxt_s;   // next state
  iss_link_if      link (); // line events

  // pin synchronisers and condition detection
  iss_line_mon u_mon (
    .clk_sys (clk_sys),
    .rst     (rst),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .link    (link)
  );

  // status and control byte as software sees it
  function automatic logic [7:0] iss_ctrl_byte(input iss_state_word_t v);
    iss_ctrl_byte = {v.done, v.match, v.busy, v.dir, v.tx_ack_bit, v.rw,
                     v.wake_en, v.rx_ack_flag};
  endfunction

  // exact 12-bit address compare used by read and write decode
  function automatic logic iss_hit(input logic [11:0] a,
                                   input logic [11:0] off);
    iss_hit = (a == off);
  endfunction

  logic       acc;     // apb access completes this cycle
  logic       wr;      // completing write
  logic       rd;      // completing read
  logic       data_rd; // software read of the data buffer
  logic       data_wr; // software write of the data buffer
  logic [1:0] ev;      // events raised this cycle
  logic       mapped;  // address is one of ours

  // protocol, register file and interrupt in one next-state process
  always_comb begin
    nxt_s   = s_ff;
    ev      = 2'h0;
    acc     = psel & penable & s_ff.pready;
    wr      = acc & pwrite;
    rd      = acc & ~pwrite;
    data_rd = rd & iss_hit(paddr, `ISS_OFF_DATA);
    data_wr = wr & iss_hit(paddr, `ISS_OFF_DATA);
    mapped  = iss_hit(paddr, `ISS_OFF_STAT_CTRL) |
              iss_hit(paddr, `ISS_OFF_ENABLE) |
              iss_hit(paddr, `ISS_OFF_OWN_ADDR) |
              iss_hit(paddr, `ISS_OFF_DATA) |
              iss_hit(paddr, `ISS_OFF_INT_STAT) |
              iss_hit(paddr, `ISS_OFF_INT_MASK);

    // apb: one wait state, then answer for a single cycle
    nxt_s.pready  = psel & penable & ~s_ff.pready;
    nxt_s.pslverr = psel & penable & ~s_ff.pready & ~mapped;
    nxt_s.prdata  = 32'h0;
    if (psel & penable & ~s_ff.pready & ~pwrite) begin
      case (paddr)
        `ISS_OFF_STAT_CTRL: nxt_s.prdata = {24'h0, iss_ctrl_byte(s_ff)};
        `ISS_OFF_ENABLE:    nxt_s.prdata = {31'h0, s_ff.en};
        `ISS_OFF_OWN_ADDR:  nxt_s.prdata = {24'h0, s_ff.own_addr, 1'h0};
        `ISS_OFF_DATA:      nxt_s.prdata = {24'h0, s_ff.rx_data};
        `ISS_OFF_INT_STAT:  nxt_s.prdata = {30'h0, s_ff.int_stat};
        `ISS_OFF_INT_MASK:  nxt_s.prdata = {30'h0, s_ff.int_mask};
        default:            nxt_s.prdata = 32'h0;
      endcase
    end

    // register writes; flags in the status byte are not writable
    if (wr) begin
      case (paddr)
        `ISS_OFF_STAT_CTRL: begin
          nxt_s.dir     = pwdata[`ISS_BIT_DIR];
          nxt_s.tx_ack_bit = pwdata[`ISS_BIT_TX_ACK];
          nxt_s.wake_en = pwdata[`ISS_BIT_WAKE];
        end
        `ISS_OFF_ENABLE:   nxt_s.en       = pwdata[0];
        `ISS_OFF_OWN_ADDR: nxt_s.own_addr = pwdata[7:1];
        `ISS_OFF_DATA:     nxt_s.tx_data  = pwdata[7:0];
        `ISS_OFF_INT_MASK: nxt_s.int_mask = pwdata[1:0];
        default: begin
        end
      endcase
    end

    // dummy or real read of received data clears the done flag
    if (data_rd) begin
      nxt_s.done = 1'h0;
    end

    // serial protocol, only while enabled
    if (!s_ff.en) begin
      nxt_s.st     = ISS_IDLE;
      nxt_s.sda_oe = 1'h0;
      nxt_s.scl_oe = 1'h0;
    end else if (link.start_det) begin
      // start (or repeated start) always restarts address reception
      nxt_s.st     = ISS_ADDR;
      nxt_s.cnt    = 4'h0;
      nxt_s.busy   = 1'h1;
      nxt_s.done   = 1'h0;
      nxt_s.match  = 1'h0;
      nxt_s.sda_oe = 1'h0;
      nxt_s.scl_oe = 1'h0;
    end else if (link.stop_det) begin
      nxt_s.st     = ISS_IDLE;
      nxt_s.busy   = 1'h0;
      nxt_s.done   = 1'h1;
      nxt_s.sda_oe = 1'h0;
      nxt_s.scl_oe = 1'h0;
    end else begin
      case (s_ff.st)
        ISS_ADDR: begin
          if (link.scl_rise) begin
            nxt_s.shift = {s_ff.shift[6:0], link.sda_lvl};
            nxt_s.cnt   = s_ff.cnt + 4'h1;
          end
          if (link.scl_fall && s_ff.cnt == `ISS_BYTE_BITS) begin
            // eighth bit is the direction, upper seven the address
            nxt_s.rw = s_ff.shift[0];
            if (s_ff.shift[7:1] == s_ff.own_addr) begin
              nxt_s.match  = 1'h1;
              nxt_s.sda_oe = 1'h1;
              nxt_s.st     = ISS_A_ACK;
              ev[`ISS_INT_MATCH] = 1'h1;
              if (s_ff.wake_en) begin
                nxt_s.wake = 1'h1;
              end
            end else begin
              nxt_s.match = 1'h0;
              nxt_s.st    = ISS_IDLE;
            end
          end
        end
        ISS_A_ACK, ISS_R_ACK: begin
          // ack bit done: release data, hold clock until software acts
          if (link.scl_fall) begin
            nxt_s.sda_oe = 1'h0;
            nxt_s.scl_oe = 1'h1;
            nxt_s.st     = ISS_HOLD;
          end
        end
        ISS_HOLD: begin
          // data write or dummy read lets the master go on
          if (data_wr || data_rd) begin
            nxt_s.scl_oe = 1'h0;
            nxt_s.cnt    = 4'h0;
            if (s_ff.dir) begin
              nxt_s.st     = ISS_TX;
              nxt_s.shift  = data_wr ? pwdata[7:0] : s_ff.tx_data;
              nxt_s.sda_oe = data_wr ? ~pwdata[7] : ~s_ff.tx_data[7];
            end else begin
              nxt_s.st = ISS_RX;
            end
          end
        end
        ISS_RX: begin
          if (link.scl_rise) begin
            nxt_s.shift = {s_ff.shift[6:0], link.sda_lvl};
            nxt_s.cnt   = s_ff.cnt + 4'h1;
          end
          if (link.scl_fall && s_ff.cnt == `ISS_BYTE_BITS) begin
            nxt_s.rx_data = s_ff.shift;
            nxt_s.done    = 1'h1;
            ev[`ISS_INT_DONE] = 1'h1;
            nxt_s.sda_oe  = ~s_ff.tx_ack_bit;
            nxt_s.st      = ISS_R_ACK;
          end else if (link.scl_rise) begin
            nxt_s.done = 1'h0;
          end
        end
        ISS_TX: begin
          if (link.scl_rise) begin
            nxt_s.cnt  = s_ff.cnt + 4'h1;
            nxt_s.done = 1'h0;
          end
          if (link.scl_fall) begin
            if (s_ff.cnt == `ISS_BYTE_BITS) begin
              nxt_s.sda_oe = 1'h0;        // master owns the ack bit
              nxt_s.st     = ISS_T_ACK;
            end else begin
              nxt_s.shift  = {s_ff.shift[6:0], 1'h0};
              nxt_s.sda_oe = ~s_ff.shift[6];
            end
          end
        end
        ISS_T_ACK: begin
          if (link.scl_rise) begin
            nxt_s.rx_ack_flag = link.sda_lvl;
            nxt_s.done = 1'h1;
            ev[`ISS_INT_DONE] = 1'h1;
          end
          if (link.scl_fall) begin
            // no ack ends sending and leaves data released for the stop
            if (s_ff.rx_ack_flag) begin
              nxt_s.st = ISS_IDLE;
            end else begin
              nxt_s.scl_oe = 1'h1;
              nxt_s.st     = ISS_HOLD;
            end
          end
        end
        ISS_IDLE: begin
        end
        default: begin
          nxt_s.st = ISS_IDLE;
        end
      endcase
    end

    // enable rising edge: flags to defaults, control bits kept
    nxt_s.en_prev = s_ff.en;
    if (s_ff.en && !s_ff.en_prev) begin
      nxt_s.done  = `ISS_RST_DONE;
      nxt_s.match = 1'h0;
      nxt_s.busy  = 1'h0;
      nxt_s.rw    = 1'h0;
      nxt_s.rx_ack_flag = `ISS_RST_RX_ACK;
    end

    // wake request follows the wake enable bit once raised
    if (!s_ff.wake_en) begin
      nxt_s.wake = 1'h0;
    end

    // sticky status: write one clears, a new event wins over the clear
    if (wr && iss_hit(paddr, `ISS_OFF_INT_STAT)) begin
      nxt_s.int_stat = s_ff.int_stat & ~pwdata[1:0];
    end
    nxt_s.int_stat = nxt_s.int_stat | ev;
    nxt_s.irq      = |(nxt_s.int_stat & s_ff.int_mask);
  end

  // single register bank; asynchronous reset loads constants only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_ff      <= '0;
      s_ff.done <= `ISS_RST_DONE;
      s_ff.rx_ack_flag <= `ISS_RST_RX_ACK;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from flip-flops; open drain lines only pull low
  assign pready   = s_ff.pready;
  assign prdata   = s_ff.prdata;
  assign pslverr  = s_ff.pslverr;
  assign irq      = s_ff.irq;
  assign wake_req = s_ff.wake;
  assign sda_oe   = s_ff.sda_oe;
  assign scl_oe   = s_ff.scl_oe;
  assign sda_out  = 1'b0;
  assign scl_out  = 1'b0;
endmodule

/* File: sim/iss_sva.sv */
// port assertions of the i2c slave status and control block
`timescale 1ns/10ps
module iss_sva
  import iss_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pready,
  input  wire iss_pkg::iss_word_t prdata,
  input  wire logic               pslverr,
  input  wire logic               scl_in,
  input  wire logic               scl_out,
  input  wire logic               scl_oe,
  input  wire logic               sda_out,
  input  wire logic               sda_oe,
  input  wire logic               wake_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // one wait state, then a single-cycle answer
  property p_pready_wait;
    $rose(penable) && psel |-> !pready ##1 pready ##1 !pready;
  endproperty
  a_pready_wait: assert property (p_pready_wait)
    else $error("pready not in second access cycle");
  // an error answer only rides on pready
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  // read data is zero outside the answer cycle
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("prdata not zero while idle");
  // data pin only changes while the clock line is low
  property p_sda_hold;
    $changed(sda_oe) |-> !$past(scl_in);
  endproperty
  a_sda_hold: assert property (p_sda_hold)
    else $error("sda_oe changed with clock high");
  // a stretch starts only after the clock has been low a while
  property p_stretch_low;
    $rose(scl_oe) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  a_stretch_low: assert property (p_stretch_low)
    else $error("stretch began with clock high");
  // the stretch ends only through a register access
  property p_stretch_end;
    $fell(scl_oe) |-> $past(pready) || $past(pready, 2);
  endproperty
  a_stretch_end: assert property (p_stretch_end)
    else $error("stretch released without access");
  // a wake request comes with the address acknowledge
  property p_wake;
    $rose(wake_req) |-> ##[0:2] sda_oe;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake without address acknowledge");
  // open-drain pins only ever pull low
  property p_lines;
    scl_out == 1'b0 && sda_out == 1'b0;
  endproperty
  a_lines: assert property (p_lines)
    else $error("pin driven high");
endmodule
bind iss_top iss_sva i_iss_sva (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
  .wake_req(wake_req));

/* File: sim/iss_i2c_master.sv */
// behavioural two-wire bus master facing the slave block
`timescale 1ns/10ps
module iss_i2c_master (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low,
  output logic      stuck    // a clock release never came back high
);
  // idle bus: both lines released, link clock stands still
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stuck   = 1'b0;
  end
  // release the clock, wait out a slave stretch (bounded)
  task automatic rise();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && n < 4000) begin
      #10;
      n++;
    end
    // a stretch that never ends is reported to the bench as a fault
    if (n >= 4000) begin
      stuck = 1'b1;
    end
    #40;
  endtask
  // one 160 ns bit; r is the line level seen mid-high
  task automatic xbit(input logic b, output logic r);
    sda_low = ~b;
    #40;
    rise();
    r = sda;
    #40;
    scl_low = 1'b1;
    #40;
  endtask
  // data falls while the clock is high
  task automatic start();
    sda_low = 1'b0;
    #40;
    rise();
    sda_low = 1'b1;
    #80;
    scl_low = 1'b1;
    #40;
  endtask
  // data rises while the clock is high
  task automatic stop();
    sda_low = 1'b1;
    #40;
    rise();
    sda_low = 1'b0;
    #80;
  endtask
  // msb first, then the acknowledge slot
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, ack);
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(nack, r);
  endtask
endmodule

/* File: sim/iss_top_bench.sv */
// self-checking bench of the i2c slave status and control block
`timescale 1ns/10ps
`include "iss_regs.svh"
module iss_top_bench;
  import iss_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  iss_word_t   pwdata  = 32'h0;
  iss_word_t   prdata;
  logic        pready, pslverr, scl_oe, sda_oe, irq, wake_req;
  logic        m_scl_low, m_sda_low, m_stuck;
  wire         scl_ln = !(scl_oe | m_scl_low); // pull-up when released
  wire         sda_ln = !(sda_oe | m_sda_low);
  int          fails  = 0;
  int          checks = 0;
  iss_word_t   rv;
  logic        err, ack;
  logic [7:0]  db;
  always #5 clk_sys = ~clk_sys;
  iss_top i_iss_top (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .scl_in(scl_ln),
    .scl_out(), .scl_oe(scl_oe), .sda_in(sda_ln), .sda_out(),
    .sda_oe(sda_oe), .irq(irq), .wake_req(wake_req));
  iss_i2c_master i_iss_i2c_master (.scl(scl_ln), .sda(sda_ln),
    .scl_low(m_scl_low), .sda_low(m_sda_low), .stuck(m_stuck));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // apb transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input iss_word_t d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rv  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      print_verdict();
    end
  endtask
  // read status, compare the masked bits
  task automatic st(input iss_word_t m, input iss_word_t e);
    apb(1'b0, `ISS_OFF_STAT_CTRL, 32'h0);
    chk(rv & m, e);
  endtask
  // irq is registered: let it settle first
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_sys);
    chk(irq, e);
  endtask
  task automatic t_regs();
    st(32'hff, 32'h81);
    apb(1'b1, `ISS_OFF_STAT_CTRL, 32'hff);
    st(32'hff, 32'h9b);
    apb(1'b1, `ISS_OFF_STAT_CTRL, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk(rv, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, `ISS_OFF_OWN_ADDR, 32'h74);
    apb(1'b1, `ISS_OFF_ENABLE, 32'h1);
    $display("t_regs done");
  endtask
  task automatic t_rx();
    i_iss_i2c_master.start();
    st(32'ha0, 32'h20);
    i_iss_i2c_master.wbyte(8'h74, ack);
    chk(ack, 1'b0);
    st(32'h44, 32'h40);
    irq_is(1'b0);
    apb(1'b1, `ISS_OFF_INT_MASK, 32'h3);
    irq_is(1'b1);
    apb(1'b1, `ISS_OFF_INT_STAT, 32'h1);
    irq_is(1'b0);
    apb(1'b0, `ISS_OFF_DATA, 32'h0); // dummy read frees the clock
    i_iss_i2c_master.wbyte(8'h5a, ack);
    chk(ack, 1'b0);
    st(32'h80, 32'h80);
    irq_is(1'b1);
    apb(1'b0, `ISS_OFF_DATA, 32'h0);
    chk(rv, 32'h5a);
    st(32'h80, 32'h0);
    apb(1'b1, `ISS_OFF_STAT_CTRL, 32'h08); // refuse the next byte
    i_iss_i2c_master.wbyte(8'ha5, ack);
    chk(ack, 1'b1);
    apb(1'b0, `ISS_OFF_DATA, 32'h0);
    chk(rv, 32'ha5);
    i_iss_i2c_master.stop();
    st(32'ha0, 32'h80);
    apb(1'b1, `ISS_OFF_INT_STAT, 32'h3);
    irq_is(1'b0);
    $display("t_rx done");
  endtask
  task automatic t_tx();
    i_iss_i2c_master.start();
    i_iss_i2c_master.wbyte(8'h75, ack);
    st(32'h44, 32'h44);
    apb(1'b1, `ISS_OFF_STAT_CTRL, 32'h10); // transmit
    apb(1'b1, `ISS_OFF_DATA, 32'hc3);
    i_iss_i2c_master.rbyte(1'b0, db);
    chk(db, 8'hc3);
    st(32'h81, 32'h80);
    apb(1'b1, `ISS_OFF_DATA, 32'h3c);
    i_iss_i2c_master.rbyte(1'b1, db);
    chk(db, 8'h3c);
    st(32'h01, 32'h01);
    chk(sda_ln, 1'b1);
    i_iss_i2c_master.stop();
    $display("t_tx done");
  endtask
  task automatic t_wake();
    apb(1'b1, `ISS_OFF_STAT_CTRL, 32'h02);
    i_iss_i2c_master.start();
    i_iss_i2c_master.wbyte(8'h76, ack);
    chk(ack, 1'b1);
    st(32'h40, 32'h0);
    chk(wake_req, 1'b0);
    i_iss_i2c_master.start();
    i_iss_i2c_master.wbyte(8'h74, ack);
    chk(wake_req, 1'b1);
    apb(1'b1, `ISS_OFF_STAT_CTRL, 32'h18); // wake off
    repeat (2) @(posedge clk_sys);
    chk(wake_req, 1'b0);
    apb(1'b1, `ISS_OFF_ENABLE, 32'h0);
    apb(1'b1, `ISS_OFF_ENABLE, 32'h1);
    st(32'hff, 32'h99);
    i_iss_i2c_master.stop();
    $display("t_wake done");
  endtask
  // main sequence after five reset cycles
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_rx();
    t_tx();
    t_wake();
    chk(m_stuck, 1'b0);
    print_verdict();
  end
  // watchdog against a hung link
  initial begin
    #900000;
    fails++;
    print_verdict();
  end
endmodule
